// ==== src/ref_select.sv ====
// Reference selection for the main and the secondary loop
`timescale 1ns/1ns
module ref_select
  import timing_cfg_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       priority_return_mode,
  input  wire logic       main_invalid,
  input  wire logic [3:0] force_code,
  input  wire logic [3:0] main_best,
  input  wire logic [3:0] sec_best,
  output logic [3:0]      main_top_q,
  output logic [3:0]      main_sel_q,
  output logic [3:0]      sec_top_q,
  output logic [3:0]      sec_sel_q,
  output logic            main_chg_q
);
  logic [3:0] main_top_d, main_sel_d, sec_d, forced;
  logic       main_chg_d;

  always_comb begin
    main_top_d = main_best;
    main_sel_d = main_sel_q;
    if (priority_return_mode || main_invalid || main_sel_q == REF_NONE) main_sel_d = main_best;
    forced = force_ref(force_code);
    sec_d  = (forced != REF_NONE) ? forced : sec_best;
    main_chg_d = (main_sel_d != main_sel_q);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      main_top_q <= REF_NONE; main_sel_q <= REF_NONE;
      sec_top_q <= REF_NONE; sec_sel_q <= REF_NONE; main_chg_q <= 1'b0;
    end else if (ce) begin
      main_top_q <= main_top_d; main_sel_q <= main_sel_d;
      sec_top_q <= sec_d; sec_sel_q <= sec_d; main_chg_q <= main_chg_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_priority_return_mode_follow;
    ce && priority_return_mode |=> main_sel_q == $past(main_best);
  endproperty
  a_priority_return_mode_follow: assert property (p_priority_return_mode_follow) else $error("priority_return_mode no follow");
  property p_nonrevert_hold;
    ce && !priority_return_mode && !main_invalid && main_sel_q != REF_NONE |=> $stable(main_sel_q)
      && main_top_q == $past(main_best);
  endproperty
  a_nonrevert_hold: assert property (p_nonrevert_hold) else $error("nonrevert moved");
  property p_sec_forced;
    ce && force_ref(force_code) != REF_NONE |=> sec_sel_q == $past(force_code)
      && sec_top_q == $past(force_code);
  endproperty
  a_sec_forced: assert property (p_sec_forced) else $error("forced ref not taken");
endmodule : ref_select

// ==== src/regbus_if.sv ====
// Register access carrier between the serial port and the register bank
`timescale 1ns/1ns
interface regbus_if;
  logic [8:0] addr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport master (output addr, output wr_en, output wr_data, input rd_data);
  modport slave  (input addr, input wr_en, input wr_data, output rd_data);
endinterface : regbus_if

// ==== src/spi_port.sv ====
// Serial processor port: 16-bit header, one data byte
`timescale 1ns/1ns
module spi_port
  import timing_cfg_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso_q,
  output logic      miso_oe_q,
  regbus_if.master  bus
);
  logic [2:0] sclk_s_q, sclk_s_d, cs_s_q, cs_s_d, mosi_s_q, mosi_s_d;
  logic       sclk_lv_q, sclk_lv_d, cs_lv_q, cs_lv_d, rise, fall;
  spi_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] out_q, out_d, wdat_q, wdat_d;
  logic [8:0] addr_q, addr_d;
  logic       rd_q, rd_d, load_q, load_d, wen_q, wen_d, miso_d, oe_d;

  assign bus.addr    = addr_q;
  assign bus.wr_en   = wen_q;
  assign bus.wr_data = wdat_q;

  always_comb begin
    sclk_s_d  = {sclk_s_q[1:0], sclk};
    cs_s_d    = {cs_s_q[1:0], cs_n};
    mosi_s_d  = {mosi_s_q[1:0], mosi};
    sclk_lv_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_lv_q;
    cs_lv_d   = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_lv_q;
    rise      = sclk_lv_d & ~sclk_lv_q;
    fall      = ~sclk_lv_d & sclk_lv_q;
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; out_d = out_q;
    rd_d = rd_q; load_d = 1'b0; addr_d = addr_q; wen_d = 1'b0;
    wdat_d = wdat_q; miso_d = miso_q;
    oe_d = ~cs_lv_q & rd_q & (st_q == SPI_DATA);
    if (load_q) out_d = bus.rd_data;
    case (st_q)
      SPI_IDLE: if (!cs_lv_q) begin
        st_d  = SPI_HDR;
        cnt_d = 4'h0;
      end
      SPI_HDR: if (rise) begin
        sh_d  = {sh_q[14:0], mosi_s_q[2]};
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'hf) begin
          addr_d = sh_d[8:0];
          rd_d   = sh_d[15];
          load_d = 1'b1;
          st_d   = SPI_DATA;
        end
      end
      SPI_DATA: begin
        if (fall) begin
          miso_d = out_q[7];
          out_d  = {out_q[6:0], 1'b0};
        end
        if (rise) begin
          sh_d  = {sh_q[14:0], mosi_s_q[2]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            wen_d  = ~rd_q;
            wdat_d = sh_d[7:0];
            st_d   = SPI_DONE;
          end
        end
      end
      SPI_DONE: st_d = SPI_DONE;
      default:  st_d = SPI_IDLE;
    endcase
    if (cs_lv_q) st_d = SPI_IDLE;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_s_q <= 3'h0; cs_s_q <= 3'h7; mosi_s_q <= 3'h0;
      sclk_lv_q <= 1'b0; cs_lv_q <= 1'b1; st_q <= SPI_IDLE;
      cnt_q <= 4'h0; sh_q <= 16'h0000; out_q <= 8'h00; wdat_q <= 8'h00;
      addr_q <= 9'h000; rd_q <= 1'b0; load_q <= 1'b0; wen_q <= 1'b0;
      miso_q <= 1'b0; miso_oe_q <= 1'b0;
    end else if (ce) begin
      sclk_s_q <= sclk_s_d; cs_s_q <= cs_s_d; mosi_s_q <= mosi_s_d;
      sclk_lv_q <= sclk_lv_d; cs_lv_q <= cs_lv_d; st_q <= st_d;
      cnt_q <= cnt_d; sh_q <= sh_d; out_q <= out_d; wdat_q <= wdat_d;
      addr_q <= addr_d; rd_q <= rd_d; load_q <= load_d; wen_q <= wen_d;
      miso_q <= miso_d; miso_oe_q <= oe_d;
    end
  end
endmodule : spi_port

// ==== src/timing_cfg_pkg.sv ====
// Constants, types and helper functions of the timing master configuration block
package timing_cfg_pkg;
  localparam logic [8:0]  ADDR_MAIN_CFG    = 9'h034;
  localparam logic [8:0]  ADDR_SEC_FORCE   = 9'h035;
  localparam logic [8:0]  ADDR_SPARE       = 9'h036;
  localparam logic [8:0]  ADDR_SYNTH_FAM   = 9'h038;
  localparam logic [8:0]  ADDR_SYNTH_MULT  = 9'h039;
  localparam logic [8:0]  ADDR_OUT6        = 9'h03a;
  localparam logic [8:0]  ADDR_ADJUST      = 9'h1d8;
  localparam logic [8:0]  ADDR_PAGE        = 9'h1ff;
  localparam logic [7:0]  MAIN_CFG_RST     = 8'hca;
  localparam logic [7:0]  SEC_FORCE_RST    = 8'h80;
  localparam logic [7:0]  SPARE_RST        = 8'h00;
  localparam logic [7:0]  SYNTH_FAM_RST    = 8'h1f;
  localparam logic [7:0]  SYNTH_MULT_RST   = 8'h08;
  localparam logic [7:0]  OUT6_RST         = 8'h02;
  localparam logic [7:0]  PAGE_RST         = 8'h00;
  localparam logic [7:0]  ADJUST_RST       = 8'h00;
  localparam logic [7:0]  MAIN_CFG_WMASK   = 8'hfd;
  localparam logic [7:0]  SEC_FORCE_WMASK  = 8'h0f;
  localparam logic [7:0]  SPARE_WMASK      = 8'hf2;
  localparam logic [7:0]  SYNTH_FAM_WMASK  = 8'he0;
  localparam logic [7:0]  SYNTH_MULT_WMASK = 8'hf0;
  localparam logic [7:0]  OUT6_WMASK       = 8'h03;
  localparam logic [7:0]  PAGE_ADJ_OPEN    = 8'h01;
  localparam logic [7:0]  ADJ_LIMIT_SWING  = 8'h55;
  localparam int          BIT_AUTO_FS      = 7;
  localparam int          BIT_ALARM_TO     = 6;
  localparam int          BIT_EDGE         = 5;
  localparam int          BIT_ZERO_HO      = 4;
  localparam int          BIT_EFS          = 3;
  localparam int          BIT_FAMILY       = 2;
  localparam int          BIT_PRIORITY_RETURN_MODE       = 0;
  localparam int          BIT_S2_ALT       = 7;
  localparam int          BIT_S2_FAM       = 6;
  localparam int          BIT_S1_FAM       = 5;
  localparam int          S2_MULT_LSB      = 6;
  localparam int          S1_MULT_LSB      = 4;
  localparam logic [1:0]  OUT6_OFF         = 2'h0;
  localparam logic [1:0]  OUT6_PECL        = 2'h1;
  localparam logic [3:0]  REF_NONE         = 4'h0;
  localparam logic [15:0] KHZ_E1           = 16'h0800;
  localparam logic [15:0] KHZ_DS1          = 16'h0608;
  localparam logic [15:0] KHZ_OC           = 16'h4bf0;
  localparam logic [15:0] KHZ_DS2          = 16'h18a8;
  localparam logic [15:0] KHZ_10M          = 16'h2710;
  localparam logic [2:0]  INIT_LOAD        = 3'h3;
  localparam logic [2:0]  INIT_DONE        = 3'h4;
  localparam longint      ALARM_TIMEOUT_S  = 128;
  localparam longint      CLK_HZ           = 10000000;
  localparam longint      ALARM_TIMEOUT_CYC = ALARM_TIMEOUT_S * CLK_HZ;

  typedef enum logic [3:0] {
    SPI_IDLE = 4'b0001,
    SPI_HDR  = 4'b0010,
    SPI_DATA = 4'b0100,
    SPI_DONE = 4'b1000
  } spi_state_t;

  // Bit 16 flags an undefined selection
  function automatic logic [16:0] synth_khz(input logic alt, input logic fam,
                                            input logic [1:0] m);
    logic [16:0] r;
    r = {1'b0, fam ? KHZ_DS1 : KHZ_E1} << m;
    if (alt) begin
      case ({fam, m})
        3'b100:  r = {1'b0, KHZ_OC};
        3'b101:  r = {1'b0, KHZ_OC[14:0], 1'b0};
        3'b000:  r = {1'b0, KHZ_DS2};
        3'b010:  r = {1'b0, KHZ_10M};
        default: r = {1'b1, 16'h0000};
      endcase
    end
    return r;
  endfunction : synth_khz

  function automatic logic [3:0] force_ref(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h9: force_ref = c;
      default:                      force_ref = REF_NONE;
    endcase
  endfunction : force_ref

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (nw & msk);
  endfunction : merge
endpackage : timing_cfg_pkg

// ==== src/timing_master_config_regs.sv ====
// Master configuration register group of the line-card timing device
// Contract
// - In three-pin sync mode with auto arm, reference change clears frame-sync enable.
// - Timeout bit set: phase alarms self-clear after 128 s; else software only.
// - Edge select bit picks oscillator input edge: 0 rising, 1 falling.
// - Zero-offset holdover bit makes main loop hold over at 0 ppm.
// - Frame-sync enable lets main loop watch sync pins; otherwise pins ignored.
// - Line-rate family bit sets code 0001 rate: 0 is 2048 kHz, 1 is 1544 kHz.
// - Reset loads line-rate and both synthesizer family bits from the family pin.
// - Revertive main loop, and always the secondary, switch at once to better input.
// - Nonrevertive main loop only moves a better input to the top table entry.
// - Secondary force codes 3..6 and 9 force inputs; 0 and 15 mean automatic.
// - A forced secondary input gets top priority and becomes the selected reference.
// - Activity monitors keep running and reporting while a reference is forced.
// - Spare bits and input 6 format bit store and read back, affecting nothing.
// - Synth two alternate bit picks E1/DS1 multiples or 6.312, 10, 19.44, 38.88 MHz set.
// - Synth two multiple field picks x1..x8 or the alternate frequency table.
// - Synth one multiple field picks x1..x8 of 1544 or 2048 kHz by family.
// - Output 6 format: 00 powered down, 01 LVPECL, 10 and 11 LVDS.
`timescale 1ns/1ns
module timing_master_config_regs
  import timing_cfg_pkg::*;
#(
  parameter logic [30:0] ALARM_CYCLES = 31'(ALARM_TIMEOUT_CYC)
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  input  wire logic       family_pin,
  input  wire logic       three_pin_sync_mode,
  input  wire logic [2:0] frame_sync_pins,
  input  wire logic       phase_alarm_raise,
  input  wire logic       phase_alarm_sw_clear,
  input  wire logic [3:0] main_best_ref,
  input  wire logic       main_sel_invalid,
  input  wire logic [3:0] sec_best_ref,
  output logic            phase_alarm,
  output logic            osc_edge_falling,
  output logic            zero_offset_holdover,
  output logic            frame_sync_seen,
  output logic [15:0]     code1_rate_khz,
  output logic [3:0]      top_priority_ref,
  output logic [3:0]      selected_ref_field,
  output logic [3:0]      sec_top_ref,
  output logic [3:0]      sec_selected_ref,
  output logic [4:0]      monitor_run,
  output logic [15:0]     synth_one_khz,
  output logic [15:0]     synth_two_khz,
  output logic            synth_two_undef,
  output logic            out6_enable,
  output logic            out6_lvpecl,
  output logic            out6_swing_limit
);
  regbus_if bus ();

  logic [7:0]  main_cfg_q, main_cfg_d;
  logic [7:0]  sec_force_q, sec_force_d;
  logic [7:0]  spare_q, spare_d;
  logic [7:0]  fam_q, fam_d;
  logic [7:0]  mult_q, mult_d;
  logic [7:0]  out6_q, out6_d;
  logic [7:0]  page_q, page_d;
  logic [7:0]  adjust_q, adjust_d;
  logic [7:0]  rd_data;
  logic [2:0]  fam_s_q, fam_s_d;
  logic [2:0]  init_q, init_d;
  logic [2:0]  fs0_q, fs0_d;
  logic [2:0]  fs1_q, fs1_d;
  logic [2:0]  fs2_q, fs2_d;
  logic [2:0]  fs_lv_q, fs_lv_d;
  logic        fs_seen_q, fs_seen_d;
  logic        alarm_q, alarm_d;
  logic [30:0] alarm_cnt_q, alarm_cnt_d;
  logic [15:0] code1_q, code1_d;
  logic [15:0] synth1_q, synth1_d;
  logic [16:0] synth2_q, synth2_d;
  logic        out6_en_q, out6_en_d;
  logic        out6_pecl_q, out6_pecl_d;
  logic        swing_q, swing_d;
  logic [4:0]  monitor_q, monitor_d;
  logic [16:0] s1_full;
  logic        main_chg;
  logic        timeout_hit;

  spi_port u_spi (
    .mclk      (mclk),
    .rstn      (rstn),
    .ce        (ce),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .miso_q    (miso),
    .miso_oe_q (miso_oe),
    .bus       (bus.master)
  );

  ref_select u_sel (
    .mclk         (mclk),
    .rstn         (rstn),
    .ce           (ce),
    .priority_return_mode       (main_cfg_q[BIT_PRIORITY_RETURN_MODE]),
    .main_invalid (main_sel_invalid),
    .force_code   (sec_force_q[3:0]),
    .main_best    (main_best_ref),
    .sec_best     (sec_best_ref),
    .main_top_q   (top_priority_ref),
    .main_sel_q   (selected_ref_field),
    .sec_top_q    (sec_top_ref),
    .sec_sel_q    (sec_selected_ref),
    .main_chg_q   (main_chg)
  );

  // Read mux; unmapped addresses read as zero
  always_comb begin
    case (bus.addr)
      ADDR_MAIN_CFG:   rd_data = main_cfg_q;
      ADDR_SEC_FORCE:  rd_data = sec_force_q;
      ADDR_SPARE:      rd_data = spare_q;
      ADDR_SYNTH_FAM:  rd_data = fam_q;
      ADDR_SYNTH_MULT: rd_data = mult_q;
      ADDR_OUT6:       rd_data = out6_q;
      ADDR_PAGE:       rd_data = page_q;
      ADDR_ADJUST:     rd_data = adjust_q;
      default:         rd_data = 8'h00;
    endcase
  end
  assign bus.rd_data = rd_data;

  // Register bank next state
  always_comb begin
    main_cfg_d  = main_cfg_q;
    sec_force_d = sec_force_q;
    spare_d     = spare_q;
    fam_d       = fam_q;
    mult_d      = mult_q;
    out6_d      = out6_q;
    page_d      = page_q;
    adjust_d    = adjust_q;
    fam_s_d     = {fam_s_q[1:0], family_pin};
    init_d      = (init_q == INIT_DONE) ? init_q : init_q + 3'h1;
    if (init_q == INIT_LOAD) begin
      main_cfg_d[BIT_FAMILY] = fam_s_q[2];
      fam_d[BIT_S2_FAM]      = fam_s_q[2];
      fam_d[BIT_S1_FAM]      = fam_s_q[2];
    end
    if (three_pin_sync_mode && main_cfg_q[BIT_AUTO_FS] && main_chg) begin
      main_cfg_d[BIT_EFS] = 1'b0;
    end
    if (bus.wr_en) begin
      case (bus.addr)
        ADDR_MAIN_CFG:   main_cfg_d  = merge(main_cfg_d, bus.wr_data, MAIN_CFG_WMASK);
        ADDR_SEC_FORCE:  sec_force_d = merge(sec_force_q, bus.wr_data, SEC_FORCE_WMASK);
        ADDR_SPARE:      spare_d     = merge(spare_q, bus.wr_data, SPARE_WMASK);
        ADDR_SYNTH_FAM:  fam_d       = merge(fam_d, bus.wr_data, SYNTH_FAM_WMASK);
        ADDR_SYNTH_MULT: mult_d      = merge(mult_q, bus.wr_data, SYNTH_MULT_WMASK);
        ADDR_OUT6:       out6_d      = merge(out6_q, bus.wr_data, OUT6_WMASK);
        ADDR_PAGE:       page_d      = bus.wr_data;
        ADDR_ADJUST: begin
          if (page_q == PAGE_ADJ_OPEN) adjust_d = bus.wr_data;
        end
        default:         page_d      = page_q;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      main_cfg_q  <= MAIN_CFG_RST;
      sec_force_q <= SEC_FORCE_RST;
      spare_q     <= SPARE_RST;
      fam_q       <= SYNTH_FAM_RST;
      mult_q      <= SYNTH_MULT_RST;
      out6_q      <= OUT6_RST;
      page_q      <= PAGE_RST;
      adjust_q    <= ADJUST_RST;
      fam_s_q     <= 3'h0;
      init_q      <= 3'h0;
    end else if (ce) begin
      main_cfg_q  <= main_cfg_d;
      sec_force_q <= sec_force_d;
      spare_q     <= spare_d;
      fam_q       <= fam_d;
      mult_q      <= mult_d;
      out6_q      <= out6_d;
      page_q      <= page_d;
      adjust_q    <= adjust_d;
      fam_s_q     <= fam_s_d;
      init_q      <= init_d;
    end
  end

  // Frame-sync pins, phase alarm and derived settings
  always_comb begin
    fs0_d   = frame_sync_pins;
    fs1_d   = fs0_q;
    fs2_d   = fs1_q;
    fs_lv_d = (fs_lv_q & ~(fs1_q ^ fs2_q)) | 3'h0;
    fs_lv_d = ((fs1_q ~^ fs2_q) & fs2_q) | ((fs1_q ^ fs2_q) & fs_lv_q);
    fs_seen_d = main_cfg_q[BIT_EFS] & |(fs_lv_d & ~fs_lv_q);
    timeout_hit = main_cfg_q[BIT_ALARM_TO] && (alarm_cnt_q == ALARM_CYCLES - 31'h1);
    alarm_d     = alarm_q;
    alarm_cnt_d = 31'h0;
    if (alarm_q && main_cfg_q[BIT_ALARM_TO]) alarm_cnt_d = alarm_cnt_q + 31'h1;
    if (phase_alarm_sw_clear || timeout_hit) alarm_d = 1'b0;
    if (phase_alarm_raise) begin
      alarm_d     = 1'b1;
      alarm_cnt_d = 31'h0;
    end
    code1_d   = main_cfg_q[BIT_FAMILY] ? KHZ_DS1 : KHZ_E1;
    s1_full   = synth_khz(1'b0, fam_q[BIT_S1_FAM], mult_q[S1_MULT_LSB +: 2]);
    synth1_d  = s1_full[15:0];
    synth2_d  = synth_khz(fam_q[BIT_S2_ALT], fam_q[BIT_S2_FAM],
                          mult_q[S2_MULT_LSB +: 2]);
    out6_en_d   = out6_q[1:0] != OUT6_OFF;
    out6_pecl_d = out6_q[1:0] == OUT6_PECL;
    swing_d     = out6_pecl_d && adjust_q == ADJ_LIMIT_SWING;
    monitor_d   = 5'h1f;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fs0_q       <= 3'h0;
      fs1_q       <= 3'h0;
      fs2_q       <= 3'h0;
      fs_lv_q     <= 3'h0;
      fs_seen_q   <= 1'b0;
      alarm_q     <= 1'b0;
      alarm_cnt_q <= 31'h0;
      code1_q     <= KHZ_E1;
      synth1_q    <= KHZ_E1;
      synth2_q    <= {1'b0, KHZ_E1};
      out6_en_q   <= 1'b1;
      out6_pecl_q <= 1'b0;
      swing_q     <= 1'b0;
      monitor_q   <= 5'h1f;
    end else if (ce) begin
      fs0_q       <= fs0_d;
      fs1_q       <= fs1_d;
      fs2_q       <= fs2_d;
      fs_lv_q     <= fs_lv_d;
      fs_seen_q   <= fs_seen_d;
      alarm_q     <= alarm_d;
      alarm_cnt_q <= alarm_cnt_d;
      code1_q     <= code1_d;
      synth1_q    <= synth1_d;
      synth2_q    <= synth2_d;
      out6_en_q   <= out6_en_d;
      out6_pecl_q <= out6_pecl_d;
      swing_q     <= swing_d;
      monitor_q   <= monitor_d;
    end
  end

  assign phase_alarm          = alarm_q;
  assign osc_edge_falling     = main_cfg_q[BIT_EDGE];
  assign zero_offset_holdover = main_cfg_q[BIT_ZERO_HO];
  assign frame_sync_seen      = fs_seen_q;
  assign code1_rate_khz       = code1_q;
  assign monitor_run          = monitor_q;
  assign synth_one_khz        = synth1_q;
  assign synth_two_khz        = synth2_q[15:0];
  assign synth_two_undef      = synth2_q[16];
  assign out6_enable          = out6_en_q;
  assign out6_lvpecl          = out6_pecl_q;
  assign out6_swing_limit     = swing_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_fs_autoclear;
    ce && three_pin_sync_mode && main_cfg_q[BIT_AUTO_FS] && main_chg
      && !(bus.wr_en && bus.addr == ADDR_MAIN_CFG) |=> !main_cfg_q[BIT_EFS];
  endproperty
  a_fs_autoclear: assert property (p_fs_autoclear) else $error("enable kept");

  property p_alarm_timeout;
    ce && alarm_q && main_cfg_q[BIT_ALARM_TO] && alarm_cnt_q == ALARM_CYCLES - 31'h1
      && !phase_alarm_raise |=> !alarm_q;
  endproperty
  a_alarm_timeout: assert property (p_alarm_timeout) else $error("alarm stuck");

  property p_alarm_hold;
    ce && alarm_q && !main_cfg_q[BIT_ALARM_TO] && !phase_alarm_sw_clear |=> alarm_q;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm self-cleared");

  property p_fs_ignore;
    ce && !main_cfg_q[BIT_EFS] |=> !frame_sync_seen;
  endproperty
  a_fs_ignore: assert property (p_fs_ignore) else $error("sync pin not ignored");

  property p_code1_rate;
    ce |=> code1_rate_khz == ($past(main_cfg_q[BIT_FAMILY]) ? KHZ_DS1 : KHZ_E1);
  endproperty
  a_code1_rate: assert property (p_code1_rate) else $error("code 0001 rate wrong");

  property p_family_latch;
    ce && init_q == INIT_LOAD && !bus.wr_en |=> main_cfg_q[BIT_FAMILY] == $past(fam_s_q[2])
      && fam_q[BIT_S1_FAM] == $past(fam_s_q[2]) && fam_q[BIT_S2_FAM] == $past(fam_s_q[2]);
  endproperty
  a_family_latch: assert property (p_family_latch) else $error("pin not latched");

  property p_spare_rw;
    ce && bus.wr_en && bus.addr == ADDR_SPARE |=> spare_q == ($past(bus.wr_data) & SPARE_WMASK);
  endproperty
  a_spare_rw: assert property (p_spare_rw) else $error("spare readback wrong");

  property p_out6_decode;
    ce |=> out6_enable == ($past(out6_q[1:0]) != OUT6_OFF)
      && out6_lvpecl == ($past(out6_q[1:0]) == OUT6_PECL);
  endproperty
  a_out6_decode: assert property (p_out6_decode) else $error("output 6 decode");

  property p_synth1;
    ce |=> synth_one_khz == ($past(fam_q[BIT_S1_FAM]) ? KHZ_DS1 : KHZ_E1)
      << $past(mult_q[S1_MULT_LSB +: 2]);
  endproperty
  a_synth1: assert property (p_synth1) else $error("synth one rate wrong");

  property p_synth2_plain;
    ce && !fam_q[BIT_S2_ALT] |=> !synth_two_undef
      && synth_two_khz == ($past(fam_q[BIT_S2_FAM]) ? KHZ_DS1 : KHZ_E1)
      << $past(mult_q[S2_MULT_LSB +: 2]);
  endproperty
  a_synth2_plain: assert property (p_synth2_plain) else $error("synth two rate wrong");

  property p_synth2_undef;
    ce && fam_q[BIT_S2_ALT] && mult_q[S2_MULT_LSB +: 2] == 2'h3 |=> synth_two_undef;
  endproperty
  a_synth2_undef: assert property (p_synth2_undef) else $error("synth two undef");

  property p_sec_auto;
    ce && (sec_force_q[3:0] == REF_NONE || sec_force_q[3:0] == 4'hf)
      |=> sec_selected_ref == $past(sec_best_ref);
  endproperty
  a_sec_auto: assert property (p_sec_auto) else $error("automatic select wrong");
endmodule : timing_master_config_regs

// ==== verification/test_timing_master_config_regs.sv ====
// Self-checking bench of the master configuration register group
`timescale 1ns/1ns
module test_timing_master_config_regs
  import timing_cfg_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        sclk = 1'b0;
  logic        cs_n = 1'b1;
  logic        mosi = 1'b0;
  logic        raise = 1'b0;
  logic        clr = 1'b0;
  logic [3:0]  main_best = 4'h3;
  logic [3:0]  sec_best = 4'h4;
  logic        miso, pa, o6e, o6p, osc_f, zho, fss, s2u, swl;
  logic [3:0]  top, sec_sel, msel;
  logic [15:0] s1, c1, q, s2;
  logic [16:0] e2;
  logic [4:0]  mon;
  logic        tps = 1'b0;
  logic [2:0]  fsp = 3'h0;
  logic [7:0]  r;
  logic [8:0]  ra [7] = '{ADDR_MAIN_CFG, ADDR_SEC_FORCE, ADDR_SPARE, ADDR_SYNTH_FAM,
                          ADDR_SYNTH_MULT, ADDR_OUT6, 9'h037};
  logic [7:0]  rv [7] = '{8'hce, 8'h80, 8'h00, 8'h7f, 8'h08, 8'h02, 8'h00};
  int          fail_count = 0;
  int          compares = 0;
  int          seed = 32'h8662;
  int          i;

  always #50 mclk = ~mclk;

  timing_master_config_regs #(.ALARM_CYCLES(31'd20)) dut_u (
    .mclk(mclk), .rstn(rstn), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(), .family_pin(1'b1), .three_pin_sync_mode(tps),
    .frame_sync_pins(fsp), .phase_alarm_raise(raise), .phase_alarm_sw_clear(clr),
    .main_best_ref(main_best), .main_sel_invalid(1'b0), .sec_best_ref(sec_best),
    .phase_alarm(pa), .osc_edge_falling(osc_f), .zero_offset_holdover(zho),
    .frame_sync_seen(fss), .code1_rate_khz(c1), .top_priority_ref(top),
    .selected_ref_field(msel), .sec_top_ref(), .sec_selected_ref(sec_sel),
    .monitor_run(mon), .synth_one_khz(s1), .synth_two_khz(s2), .synth_two_undef(s2u),
    .out6_enable(o6e), .out6_lvpecl(o6p), .out6_swing_limit(swl)
  );

  function automatic logic [3:0] exp_sel(input logic [3:0] c, input logic [3:0] b);
    return (c inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h9}) ? c : b;
  endfunction : exp_sel

  // Synth two rate in kHz, bit 16 marks an undefined code; c is {alt, family, multiple}
  function automatic logic [16:0] exp_s2(input logic [3:0] c);
    case (c)
      4'hc:    return 17'h04bf0;
      4'hd:    return 17'h097e0;
      4'h8:    return 17'h018a8;
      4'ha:    return 17'h02710;
      default: return c[3] ? 17'h10000 : {1'b0, (c[2] ? KHZ_DS1 : KHZ_E1) << c[1:0]};
    endcase
  endfunction : exp_s2

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic xfer(input logic rd, input logic [8:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {rd, 6'h00, a, d};
    cs_n = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      mosi = f[b];
      repeat (8) @(negedge mclk);
      q = {8'h00, q[6:0], miso};
      sclk = 1'b1;
      repeat (8) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge mclk);
    cs_n = 1'b1;
    repeat (16) @(negedge mclk);
  endtask : xfer

  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    chk("code1", c1, KHZ_DS1);
    for (i = 0; i < 7; i++) begin
      xfer(1'b1, ra[i], 8'h00);
      chk("reset", q, {8'h00, rv[i]});
    end
    xfer(1'b0, ADDR_MAIN_CFG, 8'hfa);
    chk("code1", c1, KHZ_E1);
    chk("osc_edge", {14'h0000, osc_f, zho}, 16'h0003);
    r = 8'($random(seed));
    xfer(1'b0, ADDR_SPARE, r);
    xfer(1'b1, ADDR_SPARE, 8'h00);
    chk("spare", q, {8'h00, r & 8'hf2});
    for (i = 0; i < 16; i++) begin
      xfer(1'b0, ADDR_SYNTH_FAM, {i[3], i[2], i[2], 5'h00});
      xfer(1'b0, ADDR_SYNTH_MULT, {i[1:0], i[1:0], 4'h0});
      e2 = exp_s2(i[3:0]);
      chk("synth1", s1, (i[2] ? KHZ_DS1 : KHZ_E1) << i[1:0]);
      chk("synth2", s2, e2[15:0]);
      chk("synth2_undef", {15'h0000, s2u}, {15'h0000, e2[16]});
    end
    for (i = 0; i < 16; i++) begin
      sec_best = 4'($random(seed));
      main_best = 4'($random(seed));
      xfer(1'b0, ADDR_SEC_FORCE, {4'h0, i[3:0]});
      chk("sec_sel", {12'h000, sec_sel}, {12'h000, exp_sel(i[3:0], sec_best)});
      chk("top_ref", {12'h000, top}, {12'h000, main_best});
      chk("monitor", {11'h000, mon}, 16'h001f);
    end
    for (i = 0; i < 4; i++) begin
      xfer(1'b0, ADDR_OUT6, {6'h00, i[1:0]});
      chk("out6", {14'h0000, o6e, o6p}, {14'h0000, i != 0, i == 1});
    end
    for (i = 1; i < 3; i++) begin
      xfer(1'b0, ADDR_OUT6, 8'(i));
      xfer(1'b0, ADDR_PAGE, 8'h01);
      xfer(1'b0, ADDR_ADJUST, (i == 1) ? 8'h55 : 8'h00);
      xfer(1'b0, ADDR_PAGE, 8'h00);
      chk("swing", {15'h0000, swl}, {15'h0000, i == 1});
    end
    for (i = 0; i < 2; i++) begin
      raise = 1'b1;
      @(negedge mclk);
      raise = 1'b0;
      repeat (5) @(negedge mclk);
      chk("alarm", {15'h0000, pa}, 16'h0001);
      repeat (30) @(negedge mclk);
      chk("alarm", {15'h0000, pa}, {15'h0000, i[0]});
      xfer(1'b0, ADDR_MAIN_CFG, 8'h8a);
    end
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    repeat (2) @(negedge mclk);
    chk("alarm", {15'h0000, pa}, 16'h0000);
    fsp = 3'h1;
    repeat (4) @(negedge mclk);
    chk("fsync", {15'h0000, fss}, 16'h0001);
    tps = 1'b1;
    main_best = 4'h9;
    xfer(1'b0, ADDR_MAIN_CFG, 8'h8b);
    xfer(1'b1, ADDR_MAIN_CFG, 8'h00);
    chk("auto_fs", q, 16'h0083);
    chk("main_sel", {12'h000, msel}, 16'h0009);
    chk("osc_edge", {14'h0000, osc_f, zho}, 16'h0000);
    fsp = 3'h5;
    repeat (4) @(negedge mclk);
    chk("fsync", {15'h0000, fss}, 16'h0000);
    close_out();
  end

  initial begin
    #6000000;
    fail_count++;
    close_out();
  end
endmodule : test_timing_master_config_regs
